// ### verilog/ssm_top.sv
// How it works
// RL1 - Control write requests a state transition
// RL2 - Low nibble encodes requested state
// RL3 - Acknowledge bit four clears change flag
// RL4 - Status low nibble shows current state
// RL5 - Status bit four flags change/error
// RL6 - Error code register holds last reason
// RL7 - Refused transition sets flag and code
// RL8 - Illegal transitions refused with 0011
// RL9 - Unknown state refused with 0012
// RL10 - Bad mailbox on Init-Bootstrap gives 0015
// RL11 - Bad mailbox on Init-PreOp gives 0016
// RL12 - Sync config 0017; watchdog forces SafeOp 001B
// RL13 - Output config 001D, input config 001E
// RL14 - Sixteen inputs sent as two bytes
// RL15 - Sixteen outputs taken from two bytes
// RL16 - Output channels read back as inputs
// RL17 - Reserved status bits read zero
// RL18 - Success clears code; flag held till ack
`timescale 1ns/1ps
`default_nettype none
module ssm_top import ssm_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic mbx_cfg_ok,
    input wire logic sync_cfg_ok,
    input wire logic out_cfg_ok,
    input wire logic in_cfg_ok,
    input wire logic wdog_expired,
    input wire logic [15:0] sensor_terminal,
    output logic [15:0] in_pd,
    input wire logic rx_pd_valid,
    output logic rx_pd_ready,
    input wire logic [15:0] rx_pd,
    input wire logic [15:0] out_used,
    output logic [15:0] actuator_out,
    output logic [3:0] cur_state
);
    // Reset release through two flops
    logic rst_meta_reg, rst_sync_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire rstn = rst_sync_reg;

    // Encode state for the status nibble
    function automatic logic [3:0] ssm_enc(input ssm_state_t s);
        case (s)
            SSM_ST_INIT: ssm_enc = SSM_ENC_INIT;
            SSM_ST_PREOP: ssm_enc = SSM_ENC_PREOP;
            SSM_ST_BOOT: ssm_enc = SSM_ENC_BOOT;
            SSM_ST_SAFEOP: ssm_enc = SSM_ENC_SAFEOP;
            SSM_ST_OP: ssm_enc = SSM_ENC_OP;
            default: ssm_enc = SSM_ENC_INIT;
        endcase
    endfunction : ssm_enc

    ssm_state_t state_reg, state_next;
    logic [15:0] ctrl_reg, ctrl_next;
    logic flag_reg, flag_next;
    logic [15:0] code_reg, code_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [15:0] in_pd_reg, in_pd_next;
    logic [15:0] act_reg, act_next;
    logic [3:0] cur_reg, cur_next;
    logic fifo_valid, fifo_ready;
    logic [15:0] fifo_data;
    logic ctrl_wr;
    logic [3:0] req;
    logic err;
    logic [15:0] err_code;
    ssm_state_t err_state;

    assign ctrl_wr = reg_wr && (reg_addr == SSM_OFS_CTRL); // RL1
    assign req = reg_wdata[SSM_STATE_MSB:SSM_STATE_LSB]; // RL2

    // Transition checks; errors keep or fall back the state
    always_comb begin
        err = 1'b0;
        err_code = SSM_ERR_NONE;
        err_state = state_reg;
        state_next = state_reg;
        if (ctrl_wr) begin
            state_next = state_reg;
            case (req)
                SSM_ENC_INIT: begin
                    state_next = SSM_ST_INIT;
                end
                SSM_ENC_PREOP: begin
                    if (state_reg == SSM_ST_INIT && !mbx_cfg_ok) begin
                        err = 1'b1; // RL11
                        err_code = SSM_ERR_MBX_PREOP;
                    end else if (state_reg == SSM_ST_BOOT) begin
                        err = 1'b1;
                        err_code = SSM_ERR_BAD_CHANGE;
                    end else begin
                        state_next = SSM_ST_PREOP;
                    end
                end
                SSM_ENC_BOOT: begin
                    if (state_reg == SSM_ST_BOOT) begin
                        state_next = SSM_ST_BOOT;
                    end else if (state_reg != SSM_ST_INIT) begin
                        err = 1'b1; // RL8
                        err_code = SSM_ERR_BAD_CHANGE;
                    end else if (!mbx_cfg_ok) begin
                        err = 1'b1; // RL10
                        err_code = SSM_ERR_MBX_BOOT;
                    end else begin
                        state_next = SSM_ST_BOOT;
                    end
                end
                SSM_ENC_SAFEOP: begin
                    if (state_reg == SSM_ST_INIT || state_reg == SSM_ST_BOOT) begin
                        err = 1'b1; // RL8
                        err_code = SSM_ERR_BAD_CHANGE;
                    end else if (state_reg == SSM_ST_PREOP && !sync_cfg_ok) begin
                        err = 1'b1; // RL12
                        err_code = SSM_ERR_SYNC_CFG;
                    end else if (state_reg == SSM_ST_PREOP && !out_cfg_ok) begin
                        err = 1'b1; // RL13
                        err_code = SSM_ERR_OUT_CFG;
                        err_state = SSM_ST_PREOP;
                    end else if (!in_cfg_ok) begin
                        err = 1'b1; // RL13
                        err_code = SSM_ERR_IN_CFG;
                        err_state = SSM_ST_PREOP;
                    end else begin
                        state_next = SSM_ST_SAFEOP;
                    end
                end
                SSM_ENC_OP: begin
                    if (state_reg != SSM_ST_SAFEOP && state_reg != SSM_ST_OP) begin
                        err = 1'b1; // RL8
                        err_code = SSM_ERR_BAD_CHANGE;
                    end else if (state_reg == SSM_ST_SAFEOP && !sync_cfg_ok) begin
                        err = 1'b1; // RL12
                        err_code = SSM_ERR_SYNC_CFG;
                    end else begin
                        state_next = SSM_ST_OP;
                    end
                end
                default: begin
                    err = 1'b1; // RL9
                    err_code = SSM_ERR_UNKNOWN;
                end
            endcase
        end
        // Running faults in SafeOp/Op outrank a request in the same cycle
        if (state_reg == SSM_ST_SAFEOP || state_reg == SSM_ST_OP) begin
            if (!in_cfg_ok) begin
                err = 1'b1; // RL13
                err_code = SSM_ERR_IN_CFG;
                err_state = SSM_ST_PREOP;
            end else if (!out_cfg_ok) begin
                err = 1'b1; // RL13
                err_code = SSM_ERR_OUT_CFG;
                err_state = SSM_ST_SAFEOP;
            end else if (wdog_expired) begin
                err = 1'b1; // RL12
                err_code = SSM_ERR_WATCHDOG;
                err_state = SSM_ST_SAFEOP;
            end
        end
        if (err) begin
            state_next = err_state; // RL7
        end
    end

    // Control, flag and code registers
    always_comb begin
        ctrl_next = ctrl_reg;
        flag_next = flag_reg;
        code_next = code_reg;
        if (ctrl_wr) begin
            ctrl_next = {8'h00, 3'b000, reg_wdata[4:0]}; // RL17
            if (reg_wdata[SSM_ACK_BIT]) begin
                flag_next = 1'b0; // RL3
            end
            if (!err) begin
                code_next = SSM_ERR_NONE; // RL18
            end
        end
        // Set wins over the acknowledge in the same cycle
        if (err) begin
            flag_next = 1'b1; // RL5 RL7
            code_next = err_code; // RL6
        end
    end

    // Register read mux; unmapped reads return zero
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            if (reg_addr == SSM_OFS_CTRL) begin
                rdata_next = ctrl_reg;
            end else if (reg_addr == SSM_OFS_STATUS) begin
                rdata_next = {8'h00, 3'b000, flag_reg, ssm_enc(state_reg)}; // RL4 RL17
            end else if (reg_addr == SSM_OFS_CODE) begin
                rdata_next = code_reg; // RL6
            end else begin
                rdata_next = SSM_WORD_ZERO;
            end
        end
    end

    // Process data: outputs driven in Op and one cycle after leaving it, input image with readback
    always_comb begin
        act_next = act_reg;
        if (state_reg != SSM_ST_OP) begin
            act_next = SSM_WORD_ZERO; // Safe state outside Op
        end else if (fifo_valid) begin
            act_next = fifo_data; // RL15
        end
        in_pd_next = (sensor_terminal & ~out_used) | (act_reg & out_used); // RL14 RL16
        cur_next = ssm_enc(state_next);
    end
    assign fifo_ready = 1'b1; // Actuators always accept; ce freezes the FIFO together with the consumer, so it holds words only through its read latency

    // Registered ready for the output stream: it counts every word held in the
    // buffer, memory and output stage together, and looks one word ahead
    // Trade-off: one slot of slack is lost, but a lagging ready can never overfill
    logic [3:0] fill_reg, fill_next;
    logic rdy_reg, rdy_next;
    logic rx_take;
    logic rx_give;
    always_comb begin
        rx_take = rx_pd_valid && rdy_reg; // RL15
        rx_give = fifo_valid && fifo_ready;
        fill_next = fill_reg;
        if (rx_take && !rx_give) begin
            fill_next = fill_reg + 4'h1;
        end else if (rx_give && !rx_take) begin
            fill_next = fill_reg - 4'h1;
        end
        rdy_next = (fill_next < 4'(SSM_FIFO_DEPTH));
    end

    // Fill count and ready, frozen by ce with everything but the reset synchronizer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fill_reg <= 4'h0;
            rdy_reg <= 1'b1;
        end else if (ce) begin
            fill_reg <= fill_next;
            rdy_reg <= rdy_next;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= SSM_ST_INIT;
            ctrl_reg <= SSM_CTRL_RESET;
            flag_reg <= 1'b0;
            code_reg <= SSM_ERR_NONE;
            rdata_reg <= SSM_WORD_ZERO;
            in_pd_reg <= SSM_WORD_ZERO;
            act_reg <= SSM_WORD_ZERO;
            cur_reg <= SSM_ENC_INIT;
        end else if (ce) begin
            state_reg <= state_next; // RL1
            ctrl_reg <= ctrl_next;
            flag_reg <= flag_next;
            code_reg <= code_next;
            rdata_reg <= rdata_next;
            in_pd_reg <= in_pd_next;
            act_reg <= act_next;
            cur_reg <= cur_next;
        end
    end

    ssm_fifo #(.WIDTH(SSM_FIFO_WIDTH), .DEPTH(SSM_FIFO_DEPTH)) u_rx_fifo (
        .clk(clk),
        .rst_n(rstn),
        .ce(ce),
        .in_valid(rx_take),
        .in_ready(),
        .in_data(rx_pd),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    assign reg_rdata = rdata_reg;
    assign in_pd = in_pd_reg;
    assign actuator_out = act_reg;
    assign cur_state = cur_reg;
    assign rx_pd_ready = rdy_reg;
endmodule : ssm_top
`default_nettype wire

// ### verilog/ssm_pkg.sv
package ssm_pkg;
    // Register offsets
    localparam logic [15:0] SSM_OFS_CTRL = 16'h0120;
    localparam logic [15:0] SSM_OFS_STATUS = 16'h0130;
    localparam logic [15:0] SSM_OFS_CODE = 16'h0134;
    // Field positions
    localparam int SSM_STATE_LSB = 0;
    localparam int SSM_STATE_MSB = 3;
    localparam int SSM_ACK_BIT = 4;
    localparam int SSM_FLAG_BIT = 4;
    // State encodings
    localparam logic [3:0] SSM_ENC_INIT = 4'h1;
    localparam logic [3:0] SSM_ENC_PREOP = 4'h2;
    localparam logic [3:0] SSM_ENC_BOOT = 4'h3;
    localparam logic [3:0] SSM_ENC_SAFEOP = 4'h4;
    localparam logic [3:0] SSM_ENC_OP = 4'h8;
    // Error codes
    localparam logic [15:0] SSM_ERR_NONE = 16'h0000;
    localparam logic [15:0] SSM_ERR_UNSPEC = 16'h0001;
    localparam logic [15:0] SSM_ERR_BAD_CHANGE = 16'h0011;
    localparam logic [15:0] SSM_ERR_UNKNOWN = 16'h0012;
    localparam logic [15:0] SSM_ERR_MBX_BOOT = 16'h0015;
    localparam logic [15:0] SSM_ERR_MBX_PREOP = 16'h0016;
    localparam logic [15:0] SSM_ERR_SYNC_CFG = 16'h0017;
    localparam logic [15:0] SSM_ERR_WATCHDOG = 16'h001B;
    localparam logic [15:0] SSM_ERR_OUT_CFG = 16'h001D;
    localparam logic [15:0] SSM_ERR_IN_CFG = 16'h001E;
    // Reset values
    localparam logic [15:0] SSM_CTRL_RESET = 16'h0001;
    localparam logic [15:0] SSM_WORD_ZERO = 16'h0000;
    // Process data FIFO shape
    localparam int SSM_FIFO_WIDTH = 16;
    localparam int SSM_FIFO_DEPTH = 8;
    // Slave state machine states, one-hot
    typedef enum logic [4:0] {
        SSM_ST_INIT = 5'b00001,
        SSM_ST_PREOP = 5'b00010,
        SSM_ST_BOOT = 5'b00100,
        SSM_ST_SAFEOP = 5'b01000,
        SSM_ST_OP = 5'b10000
    } ssm_state_t;
endpackage : ssm_pkg

// ### verilog/ssm_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Small register-file memory, read data registered
module ssm_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    // Storage carries no reset; the FIFO pointers guard it
    always_ff @(posedge clk) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule : ssm_mem
`default_nettype wire

// ### verilog/ssm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Valid/ready FIFO; registered memory read gives one cycle of read latency inside
module ssm_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [AW:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic ovalid_reg, ovalid_next;
    logic [WIDTH-1:0] rd_data;
    logic push, pop, load;
    logic full, empty;

    // Pointer compare with wrap bit for honest full and empty
    always_comb begin
        full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
        empty = (wptr_reg == rptr_reg);
        in_ready = !full;
        push = in_valid && !full;
        load = !empty && (!ovalid_reg || out_ready);
        pop = load;
        wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
        rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
        ovalid_next = load ? 1'b1 : (out_ready ? 1'b0 : ovalid_reg);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            ovalid_reg <= 1'b0;
        end else if (ce) begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            ovalid_reg <= ovalid_next;
        end
    end

    ssm_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk(clk),
        .ce(ce && (push || load)),
        .wr_en(push),
        .wr_addr(wptr_reg[AW-1:0]),
        .wr_data(in_data),
        .rd_addr(rptr_reg[AW-1:0]),
        .rd_data(rd_data)
    );
    // Memory read register holds the head word while the consumer stalls, until a push in a stalled cycle enables and reloads it
    assign out_valid = ovalid_reg;
    assign out_data = rd_data;
endmodule : ssm_fifo
`default_nettype wire

// ### verification/ssm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_checker import ssm_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] actuator_out,
    input wire logic [3:0] cur_state
);
    logic wr_c;
    logic rd_s;
    logic rd_c;
    // Bus events decoded once so each property stays short
    assign wr_c = ce && reg_wr && reg_addr == SSM_OFS_CTRL;
    assign rd_s = ce && reg_rd && reg_addr == SSM_OFS_STATUS;
    assign rd_c = ce && reg_rd && reg_addr == SSM_OFS_CODE;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    go_init_a: assert property (wr_c && reg_wdata[3:0] == 4'h1 |=> cur_state == 4'h1)
        else $error("init request not taken");
    bad_change_a: assert property (wr_c && reg_wdata[3:0] == 4'h8 && cur_state == 4'h1 |=> cur_state == 4'h1)
        else $error("init to op not refused");
    unknown_req_a: assert property (wr_c && !(reg_wdata[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8})
        && cur_state inside {4'h1, 4'h2} |=> $stable(cur_state)) else $error("unknown request moved state");
    flag_set_a: assert property (wr_c && reg_wdata[3:0] == 4'h8 && cur_state == 4'h1 ##2 rd_s
        |=> reg_rdata[4]) else $error("refusal left flag clear");
    state_show_a: assert property (rd_s |=> reg_rdata[3:0] == $past(cur_state))
        else $error("status nibble differs from state");
    reserved_zero_a: assert property (rd_s |=> reg_rdata[15:5] == 11'h000)
        else $error("reserved status bits set");
    code_clear_a: assert property (wr_c && reg_wdata[3:0] == 4'h1 ##2 rd_c |=> reg_rdata == 16'h0000)
        else $error("code kept after success");
    status_ro_a: assert property (ce && reg_wr && reg_addr == SSM_OFS_STATUS
        && cur_state inside {4'h1, 4'h2} |=> $stable(cur_state)) else $error("status write acted");
    act_idle_a: assert property (cur_state != 4'h8 && $past(cur_state) != 4'h8
        |-> actuator_out == 16'h0000) else $error("outputs driven outside op");
endmodule : ssm_checker
bind ssm_top ssm_checker ssm_checker_i (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .actuator_out(actuator_out),
    .cur_state(cur_state));
`default_nettype wire

// ### verification/ssm_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Fieldbus master: moves just after a falling edge, one strobe cycle per access
module ssm_master_model (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    // Idle bus from time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // Request write; reserved bits 7..5 always leave as zero
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d & 16'hFF1F;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata; // No longer qualified, so scramble it
        @(negedge clk);
    endtask : wr
    // Read; data stands from the edge after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clk);
    endtask : rd
endmodule : ssm_master_model
`default_nettype wire

// ### verification/tb_slave_state_machine_io_map.sv
`timescale 1ns/1ps
`default_nettype none
module tb_slave_state_machine_io_map import ssm_pkg::*; ;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [4:0] cfg = 5'h0F;
    logic [15:0] sensor = 16'hA5C3;
    logic [15:0] used = 16'h0000;
    logic rx_v = 1'b0;
    logic [15:0] rx_d = 16'h0000;
    logic reg_wr, reg_rd, rx_rdy;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, in_pd, act, d;
    logic [3:0] st;
    int n_mismatch = 0;
    int n_compared = 0;
    // Rows: request, {watchdog,mailbox,sync,out,in ok}, state after, code after
    logic [31:0] rows [27] = '{32'h30710015, 32'h20710016, 32'h40F10011, 32'h80F10011,
        32'h30F30000, 32'h20F30011, 32'h10F10000, 32'h20F20000, 32'h80F20011, 32'h30F20011,
        32'h50F20012, 32'h40B20017, 32'h40D2001D, 32'h40E2001E, 32'h40F40000, 32'h30F40011,
        32'h80B40017, 32'h80F80000, 32'h30F80011, 32'h40D4001D, 32'h10F10000, 32'h20F20000,
        32'h40F40000, 32'h80F80000, 32'h41F4001B, 32'h40E2001E, 32'h10F10000};
    always #50 clk = ~clk;
    ssm_master_model ssm_master_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    ssm_top ssm_top_i (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mbx_cfg_ok(cfg[3]), .sync_cfg_ok(cfg[2]),
        .out_cfg_ok(cfg[1]), .in_cfg_ok(cfg[0]), .wdog_expired(cfg[4]), .sensor_terminal(sensor),
        .in_pd(in_pd), .rx_pd_valid(rx_v), .rx_pd_ready(rx_rdy), .rx_pd(rx_d), .out_used(used),
        .actuator_out(act), .cur_state(st));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        ssm_master_model_i.wr(a, v);
    endtask : wr
    task automatic rd(input logic [15:0] a);
        ssm_master_model_i.rd(a, d);
    endtask : rd
    // One output word into the buffer; a refusal lasting 20 cycles stops the run
    task automatic send(input logic [15:0] w);
        int i;
        rx_v = 1'b1;
        rx_d = w;
        for (i = 0; i < 20 && rx_rdy !== 1'b1; i++) @(negedge clk);
        if (i == 20) begin
            n_mismatch++;
            stop_test();
        end
        @(negedge clk);
        rx_v = 1'b0;
        rx_d = ~w;
        repeat (4) @(negedge clk);
    endtask : send
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        rd(SSM_OFS_CTRL);
        chk(d, SSM_CTRL_RESET);
        rd(SSM_OFS_STATUS);
        chk(d, 16'h0001);
        rd(SSM_OFS_CODE);
        chk(d, SSM_ERR_NONE);
        rd(16'h0200);
        chk(d, SSM_WORD_ZERO);
        chk({15'h0000, rx_rdy}, 16'h0001);
        // Every row acknowledges, so the flag must mirror a nonzero code
        foreach (rows[k]) begin
            cfg = rows[k][24:20];
            @(negedge clk);
            wr(SSM_OFS_CTRL, {12'h001, rows[k][31:28]});
            repeat (2) @(negedge clk);
            rd(SSM_OFS_STATUS);
            chk(d, {11'h000, rows[k][15:0] != 16'h0000, rows[k][19:16]});
            rd(SSM_OFS_CODE);
            chk(d, rows[k][15:0]);
        end
        // Flag stays until acknowledged, even across a good transition
        wr(SSM_OFS_CTRL, 16'h0008);
        rd(SSM_OFS_STATUS);
        chk(d, 16'h0011);
        wr(SSM_OFS_CTRL, 16'h0001);
        rd(SSM_OFS_CODE);
        chk(d, SSM_ERR_NONE);
        rd(SSM_OFS_STATUS);
        chk(d, 16'h0011);
        wr(SSM_OFS_CTRL, 16'h0011);
        rd(SSM_OFS_STATUS);
        chk(d, 16'h0001);
        rd(SSM_OFS_CTRL);
        chk(d, 16'h0011);
        wr(SSM_OFS_STATUS, 16'h0008);
        rd(SSM_OFS_STATUS);
        chk(d, 16'h0001);
        // Frozen clock enable must swallow a request
        ce = 1'b0;
        wr(SSM_OFS_CTRL, 16'h0012);
        ce = 1'b1;
        chk({12'h000, st}, 16'h0001);
        // Process data in operational: byte order and output readback
        wr(SSM_OFS_CTRL, 16'h0012);
        wr(SSM_OFS_CTRL, 16'h0014);
        wr(SSM_OFS_CTRL, 16'h0018);
        chk(in_pd, 16'hA5C3);
        used = 16'h00FF;
        send(16'h1234);
        chk(act, 16'h1234);
        chk(in_pd, 16'hA534);
        used = 16'hFF00;
        send(16'hBEEF);
        chk(act, 16'hBEEF);
        chk(in_pd, 16'hBEC3);
        wr(SSM_OFS_CTRL, 16'h0011);
        repeat (3) @(negedge clk);
        chk(act, 16'h0000);
        // Mid-run reset drops a pending error flag and code
        wr(SSM_OFS_CTRL, 16'h0008);
        rd(SSM_OFS_STATUS);
        chk(d, 16'h0011);
        rst_n = 1'b0;
        @(negedge clk);
        chk({12'h000, st}, 16'h0001);
        chk({15'h0000, rx_rdy}, 16'h0001);
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        rd(SSM_OFS_STATUS);
        chk(d, 16'h0001);
        rd(SSM_OFS_CODE);
        chk(d, SSM_ERR_NONE);
        stop_test();
    end
endmodule : tb_slave_state_machine_io_map
`default_nettype wire
